// ### verilog/cmpctl_pkg.sv
// cmpctl_pkg: register map, field positions and carrier types of the comparator control block
// assumes an 8-bit register port and a single system clock
package cmpctl_pkg;
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 2'h0;
  localparam logic [ADDR_W-1:0] IRQ_ST_ADDR = 2'h1;
  localparam logic [ADDR_W-1:0] IRQ_EN_ADDR = 2'h2;

  localparam int unsigned PIN_SEL_BIT = 7;
  localparam int unsigned ENABLE_BIT  = 6;
  localparam int unsigned POL_BIT     = 5;
  localparam int unsigned OUT_BIT     = 4;
  localparam int unsigned ROUTE_BIT   = 3;
  localparam int unsigned HYST_BIT    = 0;

  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h81;
  localparam logic [DATA_W-1:0] CTRL_WMASK = 8'he9;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;

  localparam int unsigned IRQ_CHANGE_BIT = 0;
  localparam logic [DATA_W-1:0] IRQ_MASK = 8'h01;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cmpctl_bus_t;

  typedef struct packed {
    logic pin_select;
    logic enable;
    logic polarity;
    logic route_internal;
    logic hysteresis;
  } cmpctl_cfg_t;
endpackage

// ### verilog/cmpctl_edge.sv
// cmpctl_edge: registers a level and flags each change of it
// assumes the level is synchronous to sys_clk
`timescale 1ns/1ps
module cmpctl_edge
  import cmpctl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic level_in,
  output logic      level_q,
  output logic      change
);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level_in;
    end
  end

  assign change = level_in ^ level_q;
endmodule

// ### verilog/cmpctl_portmux.sv
// cmpctl_portmux: port read-back and pull-up gating for the two comparator input pins
// assumes port direction and data registers live outside this block
`timescale 1ns/1ps
module cmpctl_portmux
  import cmpctl_pkg::*;
(
  input  wire logic       cmp_active,
  input  wire logic [1:0] port_dir,
  input  wire logic [1:0] port_data,
  input  wire logic [1:0] pin_level,
  input  wire logic [1:0] pullup_cfg,
  output logic      [1:0] port_read,
  output logic      [1:0] pullup_on
);
  // dir=1 reads zero, dir=0 reads the data latch while the comparator owns the pins
  assign port_read = cmp_active ? (port_data & ~port_dir) : pin_level;
  assign pullup_on = cmp_active ? 2'h0 : pullup_cfg;
endmodule

// ### verilog/cmpctl_top.sv
// cmpctl_top: control register, output capture, pin routing and interrupt of the comparator
// assumes the analog comparator raw result arrives synchronous to sys_clk
// Function
// - one control register gives software full comparator control and output readback
// - bits 7..0 pin sel, enable, polarity, output, routing, two unused, hysteresis
// - result captured in status bit, optionally driven onto shared pin
// - software power-down, polarity select and hysteresis option
// - pull-ups on comparator input pins disconnected while comparator enabled with pin select set
// - hysteresis enable applies small positive feedback to the comparator
// - any output change sets the comparator interrupt flag
// - flag and enable both set request the comparator interrupt vector
// - interrupt comes from the internal output bit, not the pin
// - in sleep or idle, enabled comparator changes set flag and wake core if the flag was clear
// - enabled comparator keeps running during sleep or idle
// - enabled comparator with pin select set: port reads give zero if direction one, else data
`timescale 1ns/1ps
module cmpctl_top
  import cmpctl_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              cmp_raw,
  input  wire logic              sleep_mode,
  input  wire logic [1:0]        port_dir,
  input  wire logic [1:0]        port_data,
  input  wire logic [1:0]        pin_level,
  input  wire logic [1:0]        pullup_cfg,
  output logic      [1:0]        port_read,
  output logic      [1:0]        pullup_on,
  output logic                   cmp_power_on,
  output logic                   hyst_feedback,
  output logic                   out_pin,
  output logic                   out_pin_oe_b,
  output logic                   irq,
  output logic                   wake
);
  cmpctl_bus_t bus;
  cmpctl_cfg_t cfg;
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] irq_st_q;
  logic [DATA_W-1:0] irq_st_d;
  logic [DATA_W-1:0] irq_en_q;
  logic [DATA_W-1:0] irq_en_d;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] event_vec;
  logic              cmp_result;
  logic              out_q;
  logic              out_change;
  logic              wr_ctrl;
  logic              wr_st;
  logic              wr_en;
  logic              cmp_active;
  logic              rd_ctrl;
  logic              rd_st;
  logic              rd_en;
  logic [DATA_W-1:0] st_clear;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign cfg = '{pin_select:     ctrl_q[PIN_SEL_BIT],
                 enable:         ctrl_q[ENABLE_BIT],
                 polarity:       ctrl_q[POL_BIT],
                 route_internal: ctrl_q[ROUTE_BIT],
                 hysteresis:     ctrl_q[HYST_BIT]};

  assign wr_ctrl = bus.wr && (bus.addr == CTRL_ADDR);
  assign wr_st   = bus.wr && (bus.addr == IRQ_ST_ADDR);
  assign wr_en   = bus.wr && (bus.addr == IRQ_EN_ADDR);
  assign rd_ctrl = bus.rd && (bus.addr == CTRL_ADDR);
  assign rd_st   = bus.rd && (bus.addr == IRQ_ST_ADDR);
  assign rd_en   = bus.rd && (bus.addr == IRQ_EN_ADDR);

  // analog section is live only when enabled; stays on in sleep
  assign cmp_power_on  = cfg.enable;
  assign hyst_feedback = cfg.enable && cfg.hysteresis;
  assign cmp_active    = cfg.enable && cfg.pin_select;

  chk_power_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmp_power_on == cfg.enable)
    else $error("analog power does not follow enable");

  chk_sleep_running: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sleep_mode && cfg.enable) |-> cmp_power_on)
    else $error("comparator powered down in sleep");

  chk_hyst_on: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg.enable && cfg.hysteresis) |-> hyst_feedback)
    else $error("hysteresis feedback missing");

  chk_hyst_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.hysteresis |-> !hyst_feedback)
    else $error("hysteresis feedback while disabled");

  chk_hyst_power: assert property (@(posedge sys_clk) disable iff (!rst_b)
    hyst_feedback |-> cmp_power_on)
    else $error("hysteresis feedback on a powered-down comparator");

  // disabled comparator holds its result low
  assign cmp_result = cfg.enable && (cmp_raw ^ cfg.polarity);

  chk_pol_invert: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg.enable && cfg.polarity) |=> (out_q == !$past(cmp_raw)))
    else $error("inverted polarity not applied");

  chk_pol_plain: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cfg.enable && !cfg.polarity) |=> (out_q == $past(cmp_raw)))
    else $error("plain polarity result altered");

  chk_off_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.enable |=> !out_q)
    else $error("disabled comparator output not low");

  chk_off_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!cfg.enable && !out_q) |-> !out_change)
    else $error("disabled comparator reports a change");

  cmpctl_edge u_edge (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .level_in (cmp_result),
    .level_q  (out_q),
    .change   (out_change)
  );

  // change seen on the stored status bit, not the pin
  chk_flag_source: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(irq_st_q[IRQ_CHANGE_BIT]) |-> $changed(out_q))
    else $error("flag set without a status bit change");

  cmpctl_portmux u_portmux (
    .cmp_active (cmp_active),
    .port_dir   (port_dir),
    .port_data  (port_data),
    .pin_level  (pin_level),
    .pullup_cfg (pullup_cfg),
    .port_read  (port_read),
    .pullup_on  (pullup_on)
  );

  chk_pullup_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cmp_active |-> (pullup_on == pullup_cfg))
    else $error("pull-up setting lost while pins are plain port");

  chk_port_pass: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cmp_active |-> (port_read == pin_level))
    else $error("port read not the pin level");

  // pin output registered, enable low while driving
  assign out_pin      = out_q;
  assign out_pin_oe_b = !(cfg.pin_select && !cfg.route_internal);

  chk_pin_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg.route_internal |-> out_pin_oe_b)
    else $error("pin driven while routing is internal");

  chk_pin_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !cfg.pin_select |-> out_pin_oe_b)
    else $error("pin driven while pins are plain port");

  chk_pin_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    out_pin == out_q)
    else $error("pin value differs from status bit");

  // control register: readonly and unused bits never stored
  assign ctrl_d = wr_ctrl ? (bus.wdata & CTRL_WMASK) : ctrl_q;
  assign ctrl_view = ctrl_q | ({{(DATA_W-1){1'b0}}, out_q} << OUT_BIT);

  chk_ro_output_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_q[OUT_BIT] == 1'b0)
    else $error("read-only output bit stored");

  chk_view_output: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl_view[OUT_BIT] == out_q)
    else $error("output bit not shown in control register");

  chk_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wr_ctrl |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  // set wins over write-one-to-clear
  assign event_vec = {{(DATA_W-1){1'b0}}, out_change} << IRQ_CHANGE_BIT;
  assign st_clear  = wr_st ? bus.wdata : ZERO_BYTE;
  assign irq_st_d  = ((irq_st_q & ~st_clear) | event_vec) & IRQ_MASK;
  assign irq_en_d  = wr_en ? (bus.wdata & IRQ_MASK) : irq_en_q;

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_st_q[IRQ_CHANGE_BIT] && !(wr_st && reg_wdata[IRQ_CHANGE_BIT]))
      |=> irq_st_q[IRQ_CHANGE_BIT])
    else $error("flag lost without a clear");

  chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_st && reg_wdata[IRQ_CHANGE_BIT] && !out_change) |=> !irq_st_q[IRQ_CHANGE_BIT])
    else $error("write of one did not clear flag");

  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_st && reg_wdata[IRQ_CHANGE_BIT] && out_change) |=> irq_st_q[IRQ_CHANGE_BIT])
    else $error("clear beat a simultaneous change");

  chk_flag_only_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_st_q & ~IRQ_MASK) == ZERO_BYTE)
    else $error("unused status bits set");

  chk_en_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_en |=> (irq_en_q == ($past(reg_wdata) & IRQ_MASK)))
    else $error("interrupt enable write not stored");

  chk_en_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wr_en |=> $stable(irq_en_q))
    else $error("interrupt enable changed without a write");

  chk_en_only_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_en_q & ~IRQ_MASK) == ZERO_BYTE)
    else $error("unused enable bits set");

  // unmapped address and idle cycles read as zero
  assign rdata_d = rd_ctrl ? ctrl_view :
                   rd_st   ? irq_st_q  :
                   rd_en   ? irq_en_q  : ZERO_BYTE;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_q <= ZERO_BYTE;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_q <= ZERO_BYTE;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= ZERO_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  chk_read_ctrl: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_ctrl |=> (reg_rdata == $past(ctrl_view)))
    else $error("control read data wrong");

  chk_read_status: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_st |=> (reg_rdata == $past(irq_st_q)))
    else $error("status read data wrong");

  chk_read_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rd_en |=> (reg_rdata == $past(irq_en_q)))
    else $error("enable read data wrong");

  chk_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(rd_ctrl || rd_st || rd_en) |=> (reg_rdata == ZERO_BYTE))
    else $error("read data not zero outside a read");

  // request when flag and enable both set
  assign irq  = |(irq_st_q & irq_en_q);
  // only a fresh flag wakes the core; a pre-set flag gives no fresh edge
  assign wake = sleep_mode && cfg.enable && out_change && !irq_st_q[IRQ_CHANGE_BIT];

  chk_irq_raise: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (irq_st_q[IRQ_CHANGE_BIT] && irq_en_q[IRQ_CHANGE_BIT]) |-> irq)
    else $error("enabled flag gives no interrupt");

  chk_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !irq_en_q[IRQ_CHANGE_BIT] |-> !irq)
    else $error("interrupt while disabled");

  chk_wake_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wake |-> (sleep_mode && cfg.enable))
    else $error("wake outside sleep or with comparator off");

  chk_wake_preset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sleep_mode && irq_st_q[IRQ_CHANGE_BIT]) |-> !wake)
    else $error("wake although flag was already set");

  chk_sleep_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sleep_mode && cfg.enable && out_change) |=> irq_st_q[IRQ_CHANGE_BIT])
    else $error("sleeping change did not set flag");

  chk_reset_value: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> (ctrl_q == CTRL_RESET))
    else $error("control register reset value wrong");

  chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_ctrl |=> (ctrl_q == ($past(reg_wdata) & CTRL_WMASK)))
    else $error("control write not stored");

  chk_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ctrl_view[2:1] == 2'h0))
    else $error("unused control bits not zero");

  chk_change_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    out_change |=> irq_st_q[IRQ_CHANGE_BIT])
    else $error("output change did not set flag");

  chk_out_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 (out_q == ($past(cfg.enable) && ($past(cmp_raw) ^ $past(cfg.polarity)))))
    else $error("status bit not polarity-corrected result");

  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    irq == (irq_st_q[IRQ_CHANGE_BIT] && irq_en_q[IRQ_CHANGE_BIT]))
    else $error("interrupt not flag and enable");

  chk_pullup_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmp_active |-> (pullup_on == 2'h0))
    else $error("pull-ups left on while comparator enabled");

  chk_port_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cmp_active |-> (port_read == (port_data & ~port_dir)))
    else $error("port read wrong while comparator enabled");

  chk_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !out_pin_oe_b |-> (cfg.pin_select && !cfg.route_internal && out_pin == out_q))
    else $error("pin driven when routing is internal");

  chk_wake_change: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sleep_mode && cfg.enable && out_change && !irq_st_q[IRQ_CHANGE_BIT])
      |-> wake ##1 irq_st_q[IRQ_CHANGE_BIT])
    else $error("sleeping change did not wake and flag");
endmodule

// ### tb/tb_cmpctl.sv
// tb: self-checking bench of the comparator control block, one task per scenario
// assumes cmpctl_pkg and the design files are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb
  import cmpctl_pkg::*;
;
  logic              sys_clk    = 1'b0;
  logic              rst_b      = 1'b0;
  logic [ADDR_W-1:0] reg_addr   = 2'h0;
  logic [DATA_W-1:0] reg_wdata  = 8'h00;
  logic              reg_wr     = 1'b0;
  logic              reg_rd     = 1'b0;
  logic              cmp_raw    = 1'b0;
  logic              sleep_mode = 1'b0;
  logic [1:0]        port_dir   = 2'h1;
  logic [1:0]        port_data  = 2'h3;
  logic [1:0]        pin_level  = 2'h1;
  logic [1:0]        pullup_cfg = 2'h3;
  logic [DATA_W-1:0] reg_rdata;
  logic [1:0]        port_read;
  logic [1:0]        pullup_on;
  logic              cmp_power_on;
  logic              hyst_feedback;
  logic              out_pin;
  logic              out_pin_oe_b;
  logic              irq;
  logic              wake;
  int                n_fail     = 0;
  int                cmp_count  = 0;
  int                cycles     = 0;

  cmpctl_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_raw(cmp_raw), .sleep_mode(sleep_mode), .port_dir(port_dir), .port_data(port_data),
    .pin_level(pin_level), .pullup_cfg(pullup_cfg), .port_read(port_read),
    .pullup_on(pullup_on), .cmp_power_on(cmp_power_on), .hyst_feedback(hyst_feedback),
    .out_pin(out_pin), .out_pin_oe_b(out_pin_oe_b), .irq(irq), .wake(wake));

  always #10 sys_clk = ~sys_clk;

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand one cycle only, then fall back to zero
  task automatic reg_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
    settle(1);
    `CHK(reg_rdata, ZERO_BYTE)
  endtask

  task automatic t_reset();
    reg_check(CTRL_ADDR, CTRL_RESET);
    reg_check(IRQ_ST_ADDR, ZERO_BYTE);
    `CHK(out_pin_oe_b, 1'b0)
    `CHK({cmp_power_on, hyst_feedback}, 2'h0)
  endtask

  task automatic t_enable();
    reg_write(CTRL_ADDR, 8'hf7);
    settle(3);
    reg_check(CTRL_ADDR, 8'hf1);
    `CHK(out_pin, 1'b1)
    `CHK({cmp_power_on, hyst_feedback}, 2'h3)
    `CHK(pullup_on, 2'h0)
    `CHK(port_read, 2'h2)
    reg_check(IRQ_ST_ADDR, IRQ_MASK);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_irq();
    reg_write(IRQ_EN_ADDR, IRQ_MASK);
    settle(2);
    `CHK(irq, 1'b1)
    reg_write(IRQ_ST_ADDR, IRQ_MASK);
    settle(2);
    `CHK(irq, 1'b0)
    reg_check(IRQ_ST_ADDR, ZERO_BYTE);
    reg_check(IRQ_EN_ADDR, IRQ_MASK);
  endtask

  task automatic t_route_sleep();
    reg_write(CTRL_ADDR, 8'he9);
    settle(2);
    `CHK(out_pin_oe_b, 1'b1)
    @(posedge sys_clk);
    sleep_mode <= 1'b1;
    cmp_raw    <= 1'b1;
    #1;
    `CHK(wake, 1'b1)
    `CHK(cmp_power_on, 1'b1)
    settle(2);
    `CHK(irq, 1'b1)
    reg_check(CTRL_ADDR, 8'he9);
    // flag left set before sleeping on: a change must not wake
    @(posedge sys_clk);
    cmp_raw    <= 1'b0;
    #1;
    `CHK(wake, 1'b0)
    @(posedge sys_clk);
    cmp_raw    <= 1'b1;
    sleep_mode <= 1'b0;
  endtask

  task automatic t_disable();
    reg_write(IRQ_ST_ADDR, IRQ_MASK);
    reg_write(CTRL_ADDR, 8'h81);
    settle(2);
    `CHK(pullup_on, 2'h3)
    `CHK(port_read, 2'h1)
    `CHK(cmp_power_on, 1'b0)
    `CHK(irq, 1'b0)
    reg_write(2'h3, 8'hff);
    reg_check(2'h3, ZERO_BYTE);
    reg_check(CTRL_ADDR, CTRL_RESET);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_enable();
    t_irq();
    t_route_sleep();
    t_disable();
    stop_test();
  end
endmodule
